// ==== rtl/fdc_map.vh ====
/*
  Constants for the flash data compress sequencer: command code, status
  write bit positions, timing overhead and signature analyser feedback.
  Assumes inclusion by bare name from the design files.
*/
`ifndef FDC_MAP_VH
`define FDC_MAP_VH

// Command register code of the compress operation
`define FDC_CMD_COMPRESS 8'h06

// Bit positions in a status register write
`define FDC_STAT_CMD_BUFFER_EMPTY_FLAG_BIT 7
`define FDC_STAT_ACCESS_ERROR_FLAG_BIT 4

// Fixed bus cycles added to twice the word count
`define FDC_OVERHEAD_CYCLES 18'h00012

// Word count used when the written count is zero (whole block)
`define FDC_FULL_BLOCK_WORDS 17'h10000

// Status flag values after reset
`define FDC_CMD_BUFFER_EMPTY_FLAG_RESET 1'b1
`define FDC_CMD_COMPLETE_FLAG_RESET 1'b1
`define FDC_ACCESS_ERROR_FLAG_RESET 1'b0

// Signature analyser feedback taps and reset value
`define FDC_SIGNATURE_ANALYSER_POLY 16'h1021
`define FDC_SIGNATURE_ANALYSER_RESET 16'h0000

`endif

// ==== rtl/fdc_signature_analyser.v ====
/*
  16-bit multiple-input signature register.
  Assumes the same clock and reset as the sequencer that drives it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fdc_map.vh"

module fdc_signature_analyser (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Control and data
  input wire clear,
  input wire shift_en,
  input wire [15:0] din,
  // Signature
  output reg [15:0] sig
);

  wire [15:0] next_sig;

  assign next_sig = {sig[14:0], 1'b0} ^ (sig[15] ? `FDC_SIGNATURE_ANALYSER_POLY : 16'h0000) ^ din;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sig <= `FDC_SIGNATURE_ANALYSER_RESET;
    end else if (clear) begin
      sig <= `FDC_SIGNATURE_ANALYSER_RESET;
    end else if (shift_en) begin
      sig <= next_sig;
    end
  end

endmodule // fdc_signature_analyser
`default_nettype wire

// ==== rtl/fdc_compress.v ====
/*
  Flash data compress command sequencer: takes the address/count write,
  the command code and the launch write, reads the selected words into a
  signature analyser and presents the signature with the complete flag.
  Assumes host strobes and flash read data come from logic on core_clk,
  and that flash_rd_data is valid in the cycle after flash_rd_en is high.
  One word is read on every second cycle of a run; the fixed overhead after
  the last read covers the read pipeline and the signature hand-over.
  The host is expected to wait for the complete flag and take the signature
  from flash_data_buffer before it starts the next sequence, since a new run
  overwrites it. Array, command and launch writes that arrive while a run is busy
  are refused and only set the access error flag.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fdc_map.vh"

module fdc_compress (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Host write into the flash block: word address and data
  input wire array_wr,
  input wire [15:0] array_addr,
  input wire [15:0] array_wdata,
  // Host write to the command register
  input wire cmd_wr,
  input wire [7:0] command_register,
  // Host write to the status register (write one to act)
  input wire stat_wr,
  input wire [7:0] stat_wdata,
  // Configuration
  input wire [1:0] margin_read_select,
  input wire complete_irq_enable,
  // Flash array read port
  output reg flash_rd_en,
  output reg [15:0] flash_rd_addr,
  output reg [1:0] flash_rd_margin,
  input wire [15:0] flash_rd_data,
  // Status and result
  output reg cmd_buffer_empty_flag,
  output reg cmd_complete_flag,
  output reg access_error_flag,
  output reg [15:0] flash_data_buffer,
  output reg irq
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_ADDR = 2'd1;
  localparam [1:0] ST_CMD = 2'd2;
  localparam [1:0] ST_BUSY = 2'd3;

  reg [1:0] state;
  reg [15:0] start_addr;
  reg [16:0] word_count;
  reg [17:0] total_cycles;
  reg [17:0] elapsed;
  reg data_pend;
  reg signature_analyser_clear;
  reg [1:0] next_state;
  reg [15:0] next_start_addr;
  reg [16:0] next_word_count;
  reg [17:0] next_total_cycles;

  wire [15:0] signature;
  wire launch;
  wire launch_write;
  wire clear_error;
  wire busy;
  wire seq_attempt;
  wire bad_launch;
  wire done;
  wire issue_read;

  // Decoded host writes
  assign launch_write = stat_wr && stat_wdata[`FDC_STAT_CMD_BUFFER_EMPTY_FLAG_BIT];
  assign clear_error = stat_wr && stat_wdata[`FDC_STAT_ACCESS_ERROR_FLAG_BIT];
  assign busy = (state == ST_BUSY);
  assign launch = launch_write && (state == ST_CMD);
  // A launch outside a finished sequence, or any array, command or launch write while busy, is refused
  assign bad_launch = launch_write && (state != ST_CMD) && !busy;
  assign seq_attempt = busy && (array_wr || cmd_wr || launch_write);
  // Last cycle of a run; flags and signature update on the edge ending it
  assign done = busy && (elapsed == total_cycles - 18'h00001);
  // One read on every even count while words remain
  assign issue_read = busy && !elapsed[0] && (elapsed[17:1] < word_count);

  // Signature analyser, cleared one cycle after launch
  fdc_signature_analyser fdc_signature_analyser_inst (
    .core_clk(core_clk),
    .rstn(rstn),
    .clear(signature_analyser_clear),
    .shift_en(data_pend),
    .din(flash_rd_data),
    .sig(signature)
  );

  // Next state of the command write sequence
  always @* begin
    next_state = state;
    next_start_addr = start_addr;
    next_word_count = word_count;
    next_total_cycles = total_cycles;
    case (state)
      ST_IDLE: begin
        if (array_wr) begin
          next_start_addr = array_addr;
          next_word_count = (array_wdata == 16'h0000) ? `FDC_FULL_BLOCK_WORDS : {1'b0, array_wdata};
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (cmd_wr) begin
          next_state = (command_register == `FDC_CMD_COMPRESS) ? ST_CMD : ST_IDLE;
        end else if (array_wr) begin
          next_state = ST_IDLE;
        end
      end
      ST_CMD: begin
        if (launch) begin
          next_state = ST_BUSY;
          next_total_cycles = {word_count, 1'b0} + `FDC_OVERHEAD_CYCLES;
        end else if (array_wr || cmd_wr) begin
          next_state = ST_IDLE;
        end
      end
      ST_BUSY: begin
        if (done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Command write sequence registers
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      start_addr <= 16'h0000;
      word_count <= 17'h00000;
      total_cycles <= 18'h00000;
    end else begin
      state <= next_state;
      start_addr <= next_start_addr;
      word_count <= next_word_count;
      total_cycles <= next_total_cycles;
    end
  end

  // Cycle count and array reads
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      elapsed <= 18'h00000;
      flash_rd_en <= 1'b0;
      flash_rd_addr <= 16'h0000;
      flash_rd_margin <= 2'b00;
      data_pend <= 1'b0;
      signature_analyser_clear <= 1'b0;
    end else begin
      signature_analyser_clear <= launch;
      if (launch) begin
        elapsed <= 18'h00000;
      end else if (busy) begin
        elapsed <= elapsed + 18'h00001;
      end
      flash_rd_en <= issue_read;
      // 16-bit add wraps at the block end back to its first word
      flash_rd_addr <= start_addr + elapsed[16:1];
      flash_rd_margin <= busy ? margin_read_select : 2'b00;
      data_pend <= flash_rd_en;
    end
  end

  // Status flags, result and interrupt
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_buffer_empty_flag <= `FDC_CMD_BUFFER_EMPTY_FLAG_RESET;
      cmd_complete_flag <= `FDC_CMD_COMPLETE_FLAG_RESET;
      flash_data_buffer <= 16'h0000;
      irq <= 1'b0;
    end else begin
      if (launch) begin
        cmd_buffer_empty_flag <= 1'b0;
        cmd_complete_flag <= 1'b0;
      end else if (done) begin
        cmd_buffer_empty_flag <= 1'b1;
        cmd_complete_flag <= 1'b1;
        flash_data_buffer <= signature;
      end
      irq <= complete_irq_enable && (cmd_complete_flag || done);
    end
  end

  // Sticky access error flag; a set in the same cycle beats the write-one clear
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      access_error_flag <= `FDC_ACCESS_ERROR_FLAG_RESET;
    end else if (seq_attempt || bad_launch) begin
      access_error_flag <= 1'b1;
    end else if (clear_error) begin
      access_error_flag <= 1'b0;
    end
  end

endmodule // fdc_compress
`default_nettype wire

// ==== testbench/fdc_compress_properties.sv ====
/* Port checker for the compress sequencer.
   Assumes binding to fdc_compress, single clock core_clk. */
`timescale 1ns/1ps
`default_nettype none
module fdc_compress_properties (
  // Clock, reset and host strobes
  input wire core_clk, rstn, array_wr, cmd_wr, stat_wr, complete_irq_enable,
  input wire [7:0] stat_wdata,
  input wire [1:0] margin_read_select, flash_rd_margin,
  // Read port and status
  input wire flash_rd_en, cmd_buffer_empty_flag, cmd_complete_flag, access_error_flag, irq,
  input wire [15:0] flash_rd_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chk_flags_pair: assert property (cmd_buffer_empty_flag == cmd_complete_flag) else $error("pair");
  chk_launch_clear: assert property ($fell(cmd_complete_flag) |-> $past(stat_wr && stat_wdata[7]))
    else $error("launch");
  chk_busy_error: assert property (!cmd_complete_flag && (array_wr || cmd_wr) |=> access_error_flag)
    else $error("busy");
  chk_error_hold: assert property (access_error_flag && !(stat_wr && stat_wdata[4]) |=> access_error_flag)
    else $error("hold");
  chk_irq_follow: assert property ($past(rstn) |->
    irq == ($past(complete_irq_enable) && ($past(cmd_complete_flag) || cmd_complete_flag))) else $error("irq");
  chk_read_margin: assert property (flash_rd_en |-> !cmd_complete_flag && flash_rd_margin == margin_read_select)
    else $error("margin");
  chk_read_gap: assert property (flash_rd_en |=> !flash_rd_en) else $error("gap");
  chk_addr_step: assert property (flash_rd_en && $past(flash_rd_en, 2) |->
    flash_rd_addr == $past(flash_rd_addr, 2) + 16'h0001) else $error("step");
  cover property ($rose(cmd_complete_flag));
  cover property ($rose(access_error_flag));
  cover property ($rose(irq));
endmodule // fdc_compress_properties
bind fdc_compress fdc_compress_properties fdc_compress_properties_inst (.core_clk, .rstn, .array_wr, .cmd_wr,
  .stat_wr, .complete_irq_enable, .stat_wdata, .margin_read_select, .flash_rd_margin, .flash_rd_en,
  .cmd_buffer_empty_flag, .cmd_complete_flag, .access_error_flag, .irq, .flash_rd_addr);
`default_nettype wire

// ==== testbench/fdc_compress_test.sv ====
/* Bench for the compress sequencer: command runs with timing and signature checks.
   Assumes flash words derive from their address, or read as erased words. */
`timescale 1ns/1ps
`default_nettype none
`include "fdc_map.vh"
module fdc_compress_test;
  reg core_clk = 0, rstn = 0, array_wr = 0, cmd_wr = 0, stat_wr = 0, complete_irq_enable = 0, held = 0, erased = 0;
  reg [15:0] array_addr = 16'h0000, array_wdata = 16'h0000, flash_rd_data = 16'h0000;
  reg [7:0] command_register = 8'h00, stat_wdata = 8'h00;
  reg [1:0] margin_read_select = 2'h0;
  reg [63:0] addrs = 64'h8000_1234_FFFE_0100, cnts = 64'h0002_0007_0004_0001;
  wire flash_rd_en, cmd_buffer_empty_flag, cmd_complete_flag, access_error_flag, irq;
  wire [15:0] flash_rd_addr, flash_data_buffer;
  wire [1:0] flash_rd_margin;
  integer n_mismatch = 0, cmp_count = 0, i;
  fdc_compress fdc_compress_inst (.core_clk, .rstn, .array_wr, .array_addr, .array_wdata, .cmd_wr,
    .command_register, .stat_wr, .stat_wdata, .margin_read_select, .complete_irq_enable, .flash_rd_en,
    .flash_rd_addr, .flash_rd_margin, .flash_rd_data, .cmd_buffer_empty_flag, .cmd_complete_flag,
    .access_error_flag, .flash_data_buffer, .irq);
  initial forever #10 core_clk = ~core_clk;
  function [15:0] word(input [15:0] a);
    word = erased ? 16'hFFFF : ((a << 3) ^ 16'hC35A);
  endfunction
  // Data held one cycle after a read, scrambled otherwise
  always @(negedge core_clk) begin
    flash_rd_data <= flash_rd_en ? word(flash_rd_addr) : (held ? flash_rd_data : ~flash_rd_data);
    held <= flash_rd_en;
  end
  task check(input [8*5:1] nm, input [16:0] e, input [16:0] v);
    begin
      cmp_count = cmp_count + 1;
      if (e !== v) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0s expected %0h seen %0h", nm, e, v);
      end
    end
  endtask
  task start(input [15:0] a, input [15:0] n);
    begin
      array_addr = a;
      array_wdata = n;
      array_wr = 1;
      @(negedge core_clk);
      array_wr = 0;
      cmd_wr = 1;
      command_register = `FDC_CMD_COMPRESS;
      @(negedge core_clk);
      cmd_wr = 0;
      stat_wr = 1;
      stat_wdata = 8'h80;
      @(negedge core_clk);
      stat_wr = 0;
      check("empty", 1'b0, cmd_buffer_empty_flag);
    end
  endtask
  // Wrong command code, then a launch write: refused and flagged
  task bad_seq;
    begin
      array_addr = 16'h0200;
      array_wdata = 16'h0001;
      array_wr = 1;
      @(negedge core_clk);
      array_wr = 0;
      cmd_wr = 1;
      command_register = 8'h05;
      @(negedge core_clk);
      cmd_wr = 0;
      stat_wr = 1;
      stat_wdata = 8'h80;
      @(negedge core_clk);
      stat_wr = 0;
      check("accs", 1'b1, access_error_flag);
      check("idle", 1'b1, cmd_complete_flag);
      stat_wr = 1;
      stat_wdata = 8'h10;
      @(negedge core_clk);
      stat_wr = 0;
      check("clr", 1'b0, access_error_flag);
    end
  endtask
  task run(input [15:0] a, input [15:0] n, input err);
    integer k;
    reg [15:0] s;
    begin
      start(a, n);
      s = `FDC_SIGNATURE_ANALYSER_RESET;
      for (k = 0; k < n; k = k + 1)
        s = {s[14:0], 1'b0} ^ (s[15] ? `FDC_SIGNATURE_ANALYSER_POLY : 16'h0000) ^ word(a + k[15:0]);
      k = 0;
      while (cmd_complete_flag !== 1'b1 && k < 400) begin
        cmd_wr = err && k == 4;
        @(negedge core_clk);
        k = k + 1;
      end
      check("cycle", {n, 1'b0} + 17'h00012, k[16:0]);
      check("sig", s, flash_data_buffer);
      check("err", err, access_error_flag);
      stat_wr = 1;
      stat_wdata = 8'h10;
      @(negedge core_clk);
      stat_wr = 0;
      check("irq", complete_irq_enable, irq);
    end
  endtask
  task stop_test;
    begin
      $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1;
    for (i = 0; i < 4; i = i + 1) begin
      margin_read_select = i[1:0];
      complete_irq_enable = i[0];
      run(addrs[16*i +: 16], cnts[16*i +: 16], i == 2);
    end
    bad_seq;
    start(16'h4000, 16'h0000);
    repeat (300) @(negedge core_clk);
    check("full", 1'b0, cmd_complete_flag);
    rstn = 0;
    @(negedge core_clk);
    rstn = 1;
    check("rst", 1'b1, cmd_complete_flag);
    run(16'h0010, 16'h0003, 1'b0);
    erased = 1;
    run(16'h7FFC, 16'h0008, 1'b0);
    stop_test;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
endmodule // fdc_compress_test
`default_nettype wire
